// ---- tsr_readout_regs.sv ----
// Functional notes
// - status bits 7:6 report detected supply range code
// - status bit 5 flags last reset as internal
// - status bit 4 flags factory defaults loaded at power-up
// - status bit 3 flags low supply; nonvolatile writes then blocked
// - status bit 1 shows sensing function enabled
// - status bit 0 shows digital output function enabled
// - address register bit 7 set disables bus pull-ups
// - address register bits 6:0 hold the bus slave address
// - address register writes ignored while locked
// - written address and pull-up apply only when relocked
// - select bit 7 enables scan result readout
// - select field must be one-hot, otherwise write discarded
// - selection only accepted for pins configured as sensing inputs
// - results at 82h..87h show only the selected input
// - baseline high byte at 82h, low byte at 83h
// - difference count split into high and low read-only bytes
// - raw count split into high and low read-only bytes
// - register 88h shows one on bit per button
// - lock tracks 3Ch A5h 69h unlock and 96h 5Ah C3h lock
`timescale 1ns/1ps
`default_nettype none
module tsr_readout_regs
  import tsr_pkg::*;
#(
  parameter int NBTN = 2
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // serial bus pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OEN_O,
  output logic PULLUP_DISABLE_O,
  output logic [6:0] SLAVE_ADDR_O,
  // device core status
  input wire tsr_status_type STATUS_I,
  input wire logic NVM_WRITE_REQ_I,
  output logic NVM_WRITE_GO_O,
  // sensing core results
  input wire logic [1:0] SENSE_MASK_I,
  input wire tsr_scan_type [1:0] SCAN_I,
  input wire logic [1:0] BUTTON_ON_I,
  output logic READOUT_ENABLE_O,
  output logic [1:0] BUTTON_SELECT_O
);

  if (NBTN < 1 || NBTN > 2) begin : g_nbtn_check
    $error("NBTN must be 1 or 2");
  end

  localparam logic [1:0] BTN_MASK = (NBTN == 2) ? 2'h3 : 2'h1;

  tsr_regs_type r;
  tsr_regs_type n;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rdata;
  logic [7:0] wdata;
  logic do_write;
  tsr_scan_type sel_scan;
  logic sel_valid;
  logic [7:0] unlock_exp;
  logic [7:0] lock_exp;

  ////////////////////////////////////////////////////////////////////////////
  // bus events from synchronised pins
  assign scl_rise = r.scl_s & ~r.scl_d;
  assign scl_fall = ~r.scl_s & r.scl_d;
  // start and stop only while scl is high
  assign start_c = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
  assign stop_c = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  assign sel_scan = SCAN_I[r.sel[1]];
  assign sel_valid = r.sel[SEL_RDEN_BIT] & (r.sel[1:0] != 2'h0);

  always_comb begin
    rdata = UNMAPPED_VAL;
    unique case (r.ptr)
      OFF_LOCK: begin
        rdata = {7'h00, r.address_lock_flag};
      end
      OFF_STATUS: begin
        rdata = {STATUS_I.supply_range_code,
                 STATUS_I.internal_reset_flag,
                 STATUS_I.factory_defaults_loaded,
                 STATUS_I.low_voltage_write_inhibit,
                 1'b0,
                 STATUS_I.sensing_enabled_flag,
                 STATUS_I.output_enabled_flag};
      end
      OFF_ADDR: begin
        rdata = r.addr_stage;
      end
      OFF_SEL: begin
        rdata = r.sel;
      end
      OFF_BL_HI: begin
        rdata = sel_valid ? sel_scan.baseline_value[15:8] : UNMAPPED_VAL;
      end
      OFF_BL_LO: begin
        rdata = sel_valid ? sel_scan.baseline_value[7:0] : UNMAPPED_VAL;
      end
      OFF_DIF_HI: begin
        rdata = sel_valid ? sel_scan.delta_count[15:8] : UNMAPPED_VAL;
      end
      OFF_DIF_LO: begin
        rdata = sel_valid ? sel_scan.delta_count[7:0] : UNMAPPED_VAL;
      end
      OFF_RAW_HI: begin
        rdata = sel_valid ? sel_scan.raw_count[15:8] : UNMAPPED_VAL;
      end
      OFF_RAW_LO: begin
        rdata = sel_valid ? sel_scan.raw_count[7:0] : UNMAPPED_VAL;
      end
      OFF_ON: begin
        rdata = {6'h00, BUTTON_ON_I & BTN_MASK};
      end
      default: begin
        rdata = UNMAPPED_VAL;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock sequence trackers: next byte each one expects
  always_comb begin
    unique case (r.unlock_step)
      2'h0: begin
        unlock_exp = UNLOCK_B0;
      end
      2'h1: begin
        unlock_exp = UNLOCK_B1;
      end
      default: begin
        unlock_exp = UNLOCK_B2;
      end
    endcase
    unique case (r.lock_step)
      2'h0: begin
        lock_exp = LOCK_B0;
      end
      2'h1: begin
        lock_exp = LOCK_B1;
      end
      default: begin
        lock_exp = LOCK_B2;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = r;
    wdata = r.shift;
    do_write = 1'b0;
    n.scl_m = SCL_I;
    n.scl_s = r.scl_m;
    n.scl_d = r.scl_s;
    n.sda_m = SDA_I;
    n.sda_s = r.sda_m;
    n.sda_d = r.sda_s;

    if (stop_c) begin
      n.state = ST_IDLE;
      n.sda_oen = 1'b1;
    end else if (start_c) begin
      n.state = ST_ADDR;
      n.cnt = 4'h0;
      n.first = 1'b1;
      n.sda_oen = 1'b1;
    end else begin
      unique case (r.state)
        ST_IDLE: begin
          n.sda_oen = 1'b1;
        end
        ST_ADDR, ST_WBYTE: begin
          if (scl_rise) begin
            n.shift = {r.shift[6:0], r.sda_s};
            n.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == BITS_PER_BYTE) begin
            if (r.state == ST_ADDR) begin
              if (r.shift[7:1] == r.addr_live[6:0]) begin
                n.rd = r.shift[0];
                n.sda_oen = 1'b0;
                n.state = ST_AACK;
              end else begin
                n.state = ST_IDLE;
              end
            end else begin
              if (r.first) begin
                n.ptr = r.shift;
                n.first = 1'b0;
              end else begin
                do_write = 1'b1;
                n.ptr = r.ptr + 8'h01;
              end
              n.sda_oen = 1'b0;
              n.state = ST_WACK;
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (scl_fall) begin
            n.cnt = 4'h0;
            if (r.state == ST_AACK && r.rd) begin
              n.shift = rdata;
              n.sda_oen = rdata[7];
              n.ptr = r.ptr + 8'h01;
              n.state = ST_RBYTE;
            end else begin
              n.sda_oen = 1'b1;
              n.state = ST_WBYTE;
            end
          end
        end
        ST_RBYTE: begin
          if (scl_rise) begin
            n.cnt = r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r.cnt == BITS_PER_BYTE) begin
              n.sda_oen = 1'b1;
              n.state = ST_RACK;
            end else begin
              n.shift = {r.shift[6:0], 1'b0};
              n.sda_oen = r.shift[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            n.rd = ~r.sda_s;
          end else if (scl_fall) begin
            n.cnt = 4'h0;
            if (r.rd) begin
              n.shift = rdata;
              n.sda_oen = rdata[7];
              n.ptr = r.ptr + 8'h01;
              n.state = ST_RBYTE;
            end else begin
              n.state = ST_IDLE;
            end
          end
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // register writes
    if (do_write) begin
      unique case (r.ptr)
        OFF_LOCK: begin
          // a mismatching byte restarts each tracker
          if (wdata == unlock_exp) begin
            n.unlock_step = r.unlock_step + 2'h1;
          end else begin
            n.unlock_step = (wdata == UNLOCK_B0) ? 2'h1 : 2'h0;
          end
          if (wdata == lock_exp) begin
            n.lock_step = r.lock_step + 2'h1;
          end else begin
            n.lock_step = (wdata == LOCK_B0) ? 2'h1 : 2'h0;
          end
          if (r.unlock_step == 2'h2 && wdata == UNLOCK_B2) begin
            n.address_lock_flag = 1'b0;
            n.unlock_step = 2'h0;
          end
          // staged address applies only when a relock completes
          if (r.lock_step == 2'h2 && wdata == LOCK_B2) begin
            n.address_lock_flag = 1'b1;
            n.lock_step = 2'h0;
            if (!r.address_lock_flag) begin
              n.addr_live = r.addr_stage;
            end
          end
        end
        OFF_ADDR: begin
          if (!r.address_lock_flag) begin
            n.addr_stage = wdata;
          end
        end
        OFF_SEL: begin
          if ((wdata[1:0] == SEL_BTN1 || wdata[1:0] == SEL_BTN2) &&
              (wdata[1:0] & BTN_MASK) != 2'h0 &&
              (wdata[1:0] & SENSE_MASK_I) != 2'h0) begin
            n.sel = {wdata[7], 5'h00, wdata[1:0]};
          end
        end
        default: begin
          n.sel = r.sel;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      r <= '{
        scl_m: 1'b1,
        scl_s: 1'b1,
        scl_d: 1'b1,
        sda_m: 1'b1,
        sda_s: 1'b1,
        sda_d: 1'b1,
        state: ST_IDLE,
        cnt: 4'h0,
        shift: 8'h00,
        ptr: 8'h00,
        first: 1'b0,
        rd: 1'b0,
        sda_oen: 1'b1,
        address_lock_flag: LOCK_RST,
        unlock_step: 2'h0,
        lock_step: 2'h0,
        addr_stage: ADDR_RST,
        addr_live: ADDR_RST,
        sel: SEL_RST
      };
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // open drain: the device only ever pulls low
  assign SDA_O = 1'b0;
  assign SDA_OEN_O = r.sda_oen;
  assign PULLUP_DISABLE_O = r.addr_live[ADDR_PULLUP_BIT];
  assign SLAVE_ADDR_O = r.addr_live[6:0];
  assign NVM_WRITE_GO_O = NVM_WRITE_REQ_I & ~STATUS_I.low_voltage_write_inhibit;
  assign READOUT_ENABLE_O = r.sel[SEL_RDEN_BIT];
  assign BUTTON_SELECT_O = r.sel[1:0];

endmodule
`default_nettype wire

// ---- tsr_pkg.sv ----
`default_nettype none
package tsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFF_LOCK = 8'h79;
  localparam logic [7:0] OFF_STATUS = 8'h7b;
  localparam logic [7:0] OFF_ADDR = 8'h7c;
  localparam logic [7:0] OFF_SEL = 8'h81;
  localparam logic [7:0] OFF_BL_HI = 8'h82;
  localparam logic [7:0] OFF_BL_LO = 8'h83;
  localparam logic [7:0] OFF_DIF_HI = 8'h84;
  localparam logic [7:0] OFF_DIF_LO = 8'h85;
  localparam logic [7:0] OFF_RAW_HI = 8'h86;
  localparam logic [7:0] OFF_RAW_LO = 8'h87;
  localparam logic [7:0] OFF_ON = 8'h88;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ADDR_PULLUP_BIT = 7;
  localparam int SEL_RDEN_BIT = 7;
  localparam logic [1:0] SEL_BTN1 = 2'h1;
  localparam logic [1:0] SEL_BTN2 = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // lock sequences
  localparam logic [7:0] UNLOCK_B0 = 8'h3c;
  localparam logic [7:0] UNLOCK_B1 = 8'ha5;
  localparam logic [7:0] UNLOCK_B2 = 8'h69;
  localparam logic [7:0] LOCK_B0 = 8'h96;
  localparam logic [7:0] LOCK_B1 = 8'h5a;
  localparam logic [7:0] LOCK_B2 = 8'hc3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped read value and bits per byte
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic LOCK_RST = 1'b0;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [1:0] supply_range_code;
    logic internal_reset_flag;
    logic factory_defaults_loaded;
    logic low_voltage_write_inhibit;
    logic sensing_enabled_flag;
    logic output_enabled_flag;
  } tsr_status_type;

  typedef struct packed {
    logic [15:0] baseline_value;
    logic [15:0] delta_count;
    logic [15:0] raw_count;
  } tsr_scan_type;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WBYTE = 7'h08,
    ST_WACK = 7'h10,
    ST_RBYTE = 7'h20,
    ST_RACK = 7'h40
  } tsr_state_type;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    tsr_state_type state;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic first;
    logic rd;
    logic sda_oen;
    logic address_lock_flag;
    logic [1:0] unlock_step;
    logic [1:0] lock_step;
    logic [7:0] addr_stage;
    logic [7:0] addr_live;
    logic [7:0] sel;
  } tsr_regs_type;

endpackage
`default_nettype wire

// ---- tsr_readout_regs_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsr_readout_regs_properties
  import tsr_pkg::*;
#(
  parameter int NBTN = 2
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // bus pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OEN_O,
  // configuration
  input wire logic PULLUP_DISABLE_O,
  input wire logic [6:0] SLAVE_ADDR_O,
  input wire logic READOUT_ENABLE_O,
  input wire logic [1:0] BUTTON_SELECT_O,
  input wire logic [1:0] SENSE_MASK_I,
  // core status
  input wire tsr_status_type STATUS_I,
  input wire logic NVM_WRITE_REQ_I,
  input wire logic NVM_WRITE_GO_O
);
  // cycles with both bus lines high
  logic [4:0] idle_r;
  logic [4:0] idle_nxt;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  always_comb begin
    idle_nxt = idle_r;
    if (!(SCL_I && SDA_I)) begin
      idle_nxt = 5'h00;
    end else if (idle_r != 5'h1f) begin
      idle_nxt = idle_r + 5'h01;
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    idle_r <= RSTN_I ? idle_nxt : 5'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_nvm_write_gate: assert property (
    NVM_WRITE_GO_O == (NVM_WRITE_REQ_I && !STATUS_I.low_voltage_write_inhibit))
    else $error("nvm write go wrong");
  a_sel_one_hot: assert property (BUTTON_SELECT_O != 2'b11)
    else $error("two buttons selected");
  a_sel_sensing_only: assert property (
    ($changed(BUTTON_SELECT_O) && BUTTON_SELECT_O != 2'b00)
    |-> (BUTTON_SELECT_O & $past(SENSE_MASK_I)) != 2'b00)
    else $error("non sensing pin selected");
  a_readout_needs_sel: assert property (READOUT_ENABLE_O |-> BUTTON_SELECT_O != 2'b00)
    else $error("readout on without selection");
  a_reset_values: assert property (
    $rose(RSTN_I) |-> (SDA_OEN_O && !PULLUP_DISABLE_O && SLAVE_ADDR_O == 7'h00
    && !READOUT_ENABLE_O && BUTTON_SELECT_O == 2'b00))
    else $error("reset values wrong");
  a_sda_change_low: assert property (
    (!$stable(SDA_OEN_O) || SDA_O) |-> (!SCL_I && !$past(SCL_I)))
    else $error("data changed while clock high");
  a_cfg_needs_bus: assert property (
    !$stable({PULLUP_DISABLE_O, SLAVE_ADDR_O, READOUT_ENABLE_O, BUTTON_SELECT_O})
    |-> idle_r < 5'h10)
    else $error("configuration changed without bus traffic");
  a_idle_released: assert property (idle_r >= 5'h10 |-> SDA_OEN_O)
    else $error("data line held on idle bus");
  c_ack_driven: cover property ($fell(SDA_OEN_O));
  c_addr_applied: cover property ($changed(SLAVE_ADDR_O));
  c_readout_on: cover property ($rose(READOUT_ENABLE_O));
  c_second_button: cover property (READOUT_ENABLE_O && BUTTON_SELECT_O == 2'b10);
endmodule
bind tsr_readout_regs tsr_readout_regs_properties #(.NBTN(NBTN)) i_props (
  .REF_CLK_I(REF_CLK_I),
  .RSTN_I(RSTN_I),
  .SCL_I(SCL_I),
  .SDA_I(SDA_I),
  .SDA_O(SDA_O),
  .SDA_OEN_O(SDA_OEN_O),
  .PULLUP_DISABLE_O(PULLUP_DISABLE_O),
  .SLAVE_ADDR_O(SLAVE_ADDR_O),
  .READOUT_ENABLE_O(READOUT_ENABLE_O),
  .BUTTON_SELECT_O(BUTTON_SELECT_O),
  .SENSE_MASK_I(SENSE_MASK_I),
  .STATUS_I(STATUS_I),
  .NVM_WRITE_REQ_I(NVM_WRITE_REQ_I),
  .NVM_WRITE_GO_O(NVM_WRITE_GO_O)
);
`default_nettype wire

// ---- tsr_i2c_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsr_i2c_host (
  // clock
  input wire logic clk_i,
  // bus lines, high means released
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // data moves only while the clock line is low
  task automatic bitx(input logic b, output logic r);
    w(2);
    sda_o = b;
    w(2);
    scl_o = 1'b1;
    w(4);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start;
    w(2);
    sda_o = 1'b1;
    w(2);
    scl_o = 1'b1;
    w(4);
    sda_o = 1'b0;
    w(4);
    scl_o = 1'b0;
  endtask
  task automatic stop;
    w(2);
    sda_o = 1'b0;
    w(2);
    scl_o = 1'b1;
    w(4);
    sda_o = 1'b1;
    w(8);
  endtask
  task automatic bytex(input logic [7:0] d, input logic m, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(m, a);
  endtask
  task automatic wr(input logic [6:0] sa, input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    start;
    bytex({sa, 1'b0}, 1'b1, q);
    bytex(p, 1'b1, q);
    bytex(d, 1'b1, q);
    stop;
  endtask
  // single byte read, closed by a nack
  task automatic rd(input logic [6:0] sa, input logic [7:0] p, output logic [7:0] q);
    start;
    bytex({sa, 1'b0}, 1'b1, q);
    bytex(p, 1'b1, q);
    start;
    bytex({sa, 1'b1}, 1'b1, q);
    bytex(8'hff, 1'b1, q);
    stop;
  endtask
endmodule
`default_nettype wire

// ---- tb_touch_status_readout_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_touch_status_readout_regs;
  import tsr_pkg::*;
  logic clk, rstn, scl, hsda, sda_o, oen, pud, req, go, rden;
  logic [6:0] sa;
  logic [1:0] mask, bon, bsel;
  logic [7:0] q;
  logic [7:0] seqb [6] = '{UNLOCK_B0, UNLOCK_B1, UNLOCK_B2, LOCK_B0, LOCK_B1, LOCK_B2};
  logic [31:0] seed;
  tsr_status_type st;
  tsr_scan_type [1:0] scan;
  int miscompares, comparisons;
  wire logic sda = hsda & (oen | sda_o);
  tsr_readout_regs #(.NBTN(2)) i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OEN_O(oen), .PULLUP_DISABLE_O(pud), .SLAVE_ADDR_O(sa), .STATUS_I(st),
    .NVM_WRITE_REQ_I(req), .NVM_WRITE_GO_O(go), .SENSE_MASK_I(mask), .SCAN_I(scan),
    .BUTTON_ON_I(bon), .READOUT_ENABLE_O(rden), .BUTTON_SELECT_O(bsel));
  tsr_i2c_host i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    for (int i = 0; i < 32; i++) begin
      x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    end
    return x;
  endfunction
  function automatic logic [7:0] sb(input tsr_scan_type s, input int k);
    return s[47 - 8 * k -: 8];
  endfunction
  task automatic seq(input logic [6:0] a, input int b);
    for (int i = 0; i < 3; i++) begin
      i_host.wr(a, OFF_LOCK, seqb[b + i]);
    end
  endtask
  task automatic conclude;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    conclude;
  end
  initial begin
    rstn = 1'b0;
    req = 1'b0;
    mask = 2'b01;
    bon = 2'b00;
    st = '0;
    scan = '0;
    seed = 32'hb46a4067;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      st = (i == 0) ? tsr_status_type'(7'h7f) : tsr_status_type'(seed[6:0]);
      i_host.rd(7'h00, OFF_STATUS, q);
      `CHK("status", {st[6:2], 1'b0, st[1:0]}, q)
      req = seed[7] | (i == 0);
      @(negedge clk);
      `CHK("nvm go", req & ~st.low_voltage_write_inhibit, go)
      req = 1'b0;
    end
    i_host.rd(7'h00, OFF_LOCK, q);
    `CHK("lock flag", 8'h00, q)
    i_host.wr(7'h00, OFF_ADDR, 8'haa);
    `CHK("applied addr", 8'h00, {pud, sa})
    seq(7'h00, 3);
    `CHK("applied addr", 8'haa, {pud, sa})
    i_host.rd(7'h00, OFF_STATUS, q);
    `CHK("old addr", 8'hff, q)
    i_host.rd(7'h2a, OFF_LOCK, q);
    `CHK("lock flag", 8'h01, q)
    i_host.wr(7'h2a, OFF_ADDR, 8'h33);
    i_host.rd(7'h2a, OFF_ADDR, q);
    `CHK("locked write", 8'haa, q)
    i_host.wr(7'h2a, OFF_LOCK, UNLOCK_B1);
    seq(7'h2a, 0);
    i_host.rd(7'h2a, OFF_LOCK, q);
    `CHK("lock flag", 8'h00, q)
    i_host.wr(7'h2a, OFF_ADDR, 8'h05);
    `CHK("applied addr", 8'haa, {pud, sa})
    seq(7'h2a, 3);
    `CHK("applied addr", 8'h05, {pud, sa})
    i_host.wr(7'h05, OFF_SEL, 8'h82);
    `CHK("select", 3'h0, {rden, bsel})
    i_host.wr(7'h05, OFF_SEL, 8'h83);
    `CHK("select", 3'h0, {rden, bsel})
    i_host.wr(7'h05, OFF_SEL, 8'h80);
    `CHK("select", 3'h0, {rden, bsel})
    for (int b = 0; b < 2; b++) begin
      mask = b[0] ? 2'b11 : 2'b01;
      for (int j = 0; j < 2; j++) begin
        seed = lfsr(seed);
        scan[j] = tsr_scan_type'({seed, ~seed[15:0]});
      end
      i_host.wr(7'h05, OFF_SEL, {6'h20, 2'b01 << b});
      `CHK("select", {1'b1, 2'b01 << b}, {rden, bsel})
      i_host.rd(7'h05, OFF_SEL, q);
      `CHK("select reg", {6'h20, 2'b01 << b}, q)
      for (int k = 0; k < 6; k++) begin
        i_host.rd(7'h05, 8'(OFF_BL_HI + k), q);
        `CHK("scan byte", sb(scan[b], k), q)
      end
    end
    i_host.wr(7'h05, OFF_SEL, 8'h02);
    i_host.rd(7'h05, OFF_DIF_LO, q);
    `CHK("readout off", 8'h00, q)
    seed = lfsr(seed);
    bon = seed[1:0];
    i_host.rd(7'h05, OFF_ON, q);
    `CHK("on bits", {6'h00, bon}, q)
    i_host.rd(7'h05, 8'h90, q);
    `CHK("unmapped", 8'h00, q)
    conclude;
  end
endmodule
`default_nettype wire
